// ### sfc_pkg.sv
// Purpose: shared constants for the serial memory command and protection block
// Assumes: spi modes 0 and 3, msb first, byte-wide status register
// Notes:   array addresses are 21 bits; only the protection decision is made here
package sfc_pkg;
  // opcodes
  localparam logic [7:0] LATCH_SET_CMD              = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD            = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD            = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD           = 8'h01;
  localparam logic [7:0] ARRAY_WRITE_CMD            = 8'h02;
  localparam logic [7:0] ARRAY_READ_CMD             = 8'h03;
  localparam logic [7:0] FAST_ARRAY_READ_CMD        = 8'h0B;
  localparam logic [7:0] SPECIAL_SECTOR_WRITE_CMD   = 8'h42;
  localparam logic [7:0] SPECIAL_SECTOR_READ_CMD    = 8'h4B;
  localparam logic [7:0] IDENTIFIER_READ_CMD        = 8'h9F;
  localparam logic [7:0] UNIQUE_IDENTIFIER_READ_CMD = 8'h4C;
  localparam logic [7:0] SERIAL_NUMBER_WRITE_CMD    = 8'hC2;
  localparam logic [7:0] SERIAL_NUMBER_READ_CMD     = 8'hC3;
  localparam logic [7:0] DEEP_SLEEP_CMD             = 8'hBA;
  localparam logic [7:0] HIBERNATE_CMD              = 8'hB9;
  // status register field positions
  localparam int         PIN_EN_BIT    = 7;
  localparam int         FIXED_ONE_BIT = 6;
  localparam int         BP_HIGH_BIT   = 3;
  localparam int         BP_LOW_BIT    = 2;
  localparam int         WEL_BIT       = 1;
  localparam int         BUSY_BIT      = 0;
  // status value as delivered
  localparam logic [7:0] STATUS_RESET  = 8'h40;
  // protected range starts
  localparam logic [20:0] QUARTER_BASE = 21'h180000;
  localparam logic [20:0] HALF_BASE    = 21'h100000;
  // byte counts
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [1:0] ADDR_BYTES    = 2'h3;
  // command decoder states, gray along opcode -> address -> data
  typedef enum logic [2:0] {
    SFC_OPCODE = 3'b000,
    SFC_ADDR   = 3'b001,
    SFC_DATA   = 3'b011,
    SFC_STREAM = 3'b010,
    SFC_IGNORE = 3'b110
  } sfc_state_t;
endpackage

// ### sfc_sync.sv
// Purpose: two-flop synchroniser for the serial pins
// Assumes: inputs are asynchronous to ref_clk_i
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module sfc_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  // reset value is a tie-off constant from the instantiating module
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      stage1 <= reset_val_i;
      sync_o <= reset_val_i;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// ### sfc_core.sv
// Purpose: opcode decoder, write enable latch, status register and write protection
// Assumes: sck is sampled by ref_clk_i; sck period well above four ref_clk cycles
// Notes:   array data path lives elsewhere; this block issues the per-byte write permits
//
// Overview of operation
// - decode exactly fifteen opcodes including 42h 4Bh 9Fh 4Ch C2h C3h
// - 06h sets the write enable latch, 04h clears it
// - 05h shifts out the status byte; 01h is status register write
// - array write is 02h, array read 03h, fast array read 0Bh
// - latch is clear after reset so writes are refused
// - the four write commands act only while the latch is set
// - latch clears at chip select rise ending 04h or any write command
// - status write never sets the write-enable bit
// - bit 7 pin enable, bit 3 and 2 block protect, bit 1 latch
// - bits 0, 4, 5 read zero, bit 6 reads one, writes ignored
// - bit 0 reads zero except while waking from deep sleep or hibernate
// - block protect bits are kept across power cycles
// - protect code selects none, upper quarter, upper half or whole array
// - pin ignored when enable is zero; enabled low pin blocks status writes
// - array protection uses only block protect bits and the latch
// - latch clear rejects every write; protected blocks always reject
// - delivered status value is zero except bit 6
// - first byte after chip select falls is the opcode, msb first on sck rise
// - undefined opcode ignores all input until next select, output stays off
// - only one opcode per chip select low period
// - burst write hitting a protected address stops increment, drops later bytes
`timescale 1ns/1ps
module sfc_core
  import sfc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  input  wire logic        si_i,
  input  wire logic        wp_n_i,
  input  wire logic        waking_i,
  input  wire logic [1:0]  bp_stored_i,
  input  wire logic        pin_en_stored_i,
  output logic             so_o,
  output logic             so_oe_n_o,
  output logic [7:0]       status_o,
  output logic [20:0]      addr_o,
  output logic [7:0]       wdata_o,
  output logic             array_wr_o,
  output logic             array_rd_o,
  output logic             nv_save_o,
  output logic [7:0]       opcode_o,
  output logic             opcode_valid_o
);
  logic [3:0]  pins_s;
  logic        cs_n_s;
  logic        wp_n_s;
  logic        status_wr_ok;
  logic        sck_s;
  logic        si_s;
  logic        sck_d;
  logic        cs_n_d;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        write_enable_flag;
  logic        protect_pin_enable;
  logic        block_protect_high;
  logic        block_protect_low;
  logic [7:0]  status_protect_reg;
  logic [7:0]  shift;
  logic [7:0]  next_shift;
  logic [2:0]  bit_cnt;
  logic [1:0]  addr_cnt;
  logic [7:0]  opcode;
  logic [7:0]  tx;
  logic        tx_on;
  logic        burst_halt;
  logic        loaded;
  logic        byte_done;
  sfc_state_t  state;

  // pins cross into ref_clk through two flops before anything looks at them;
  // the protect pin goes through the same pair, so a status write sees it
  // about two cycles late and the master must hold it steady across the byte
  sfc_sync #(
    .WIDTH (4)
  ) u_sync (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .async_i     ({cs_n_i, sck_i, si_i, wp_n_i}),
    .reset_val_i (4'h9),
    .sync_o      (pins_s)
  );
  assign cs_n_s = pins_s[3];
  assign sck_s  = pins_s[2];
  assign si_s   = pins_s[1];
  assign wp_n_s = pins_s[0];

  // edge detection on synchronised copies; in mode 3 the clock idles high, but
  // edges count only while selected, so the level at select needs no test
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sck_d  <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d  <= sck_s;
      cs_n_d <= cs_n_s;
    end
  end
  assign sck_rise  = sck_s & ~sck_d & ~cs_n_s;
  assign sck_fall  = ~sck_s & sck_d & ~cs_n_s;
  assign cs_fall   = ~cs_n_s & cs_n_d;
  assign cs_rise   = cs_n_s & ~cs_n_d;
  assign next_shift = {shift[6:0], si_s};
  assign byte_done = sck_rise && (bit_cnt == BIT_LAST);

  // defined opcode check, used by the decoder and the opcode strobe
  function automatic logic is_defined(input logic [7:0] op);
    case (op)
      LATCH_SET_CMD, LATCH_CLEAR_CMD, STATUS_READ_CMD, STATUS_WRITE_CMD,
      ARRAY_WRITE_CMD, ARRAY_READ_CMD, FAST_ARRAY_READ_CMD,
      SPECIAL_SECTOR_WRITE_CMD, SPECIAL_SECTOR_READ_CMD,
      IDENTIFIER_READ_CMD, UNIQUE_IDENTIFIER_READ_CMD,
      SERIAL_NUMBER_WRITE_CMD, SERIAL_NUMBER_READ_CMD,
      DEEP_SLEEP_CMD, HIBERNATE_CMD: is_defined = 1'b1;
      default:                       is_defined = 1'b0;
    endcase
  endfunction

  // opcodes whose closing select edge drops the latch
  function automatic logic clears_latch(input logic [7:0] op);
    case (op)
      LATCH_CLEAR_CMD, STATUS_WRITE_CMD, ARRAY_WRITE_CMD,
      SPECIAL_SECTOR_WRITE_CMD, SERIAL_NUMBER_WRITE_CMD: clears_latch = 1'b1;
      default:                                           clears_latch = 1'b0;
    endcase
  endfunction

  // array protection from the block protect code only
  function automatic logic addr_protected(input logic [1:0] bp, input logic [20:0] a);
    case (bp)
      2'h0:    addr_protected = 1'b0;
      2'h1:    addr_protected = (a >= QUARTER_BASE);
      2'h2:    addr_protected = (a >= HALF_BASE);
      default: addr_protected = 1'b1;
    endcase
  endfunction

  // bit counter and shift register, restarted at every select fall
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || cs_fall) begin
      bit_cnt <= 3'h0;
      shift   <= 8'h00;
    end else if (sck_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift   <= next_shift;
    end
  end

  // decoder: one opcode per frame, everything else waits for the next fall
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state    <= SFC_OPCODE;
      opcode   <= 8'h00;
      addr_cnt <= 2'h0;
    end else if (cs_fall || cs_n_s) begin
      state    <= SFC_OPCODE;
      addr_cnt <= 2'h0;
      if (cs_fall) begin
        opcode <= 8'h00;
      end
    end else begin
      case (state)
        SFC_OPCODE: begin
          if (byte_done) begin
            opcode <= next_shift;
            if (!is_defined(next_shift)) begin
              state <= SFC_IGNORE;
            end else if (next_shift == STATUS_READ_CMD) begin
              state <= SFC_STREAM;
            end else if (next_shift == STATUS_WRITE_CMD) begin
              state <= SFC_DATA;
            end else if (next_shift == ARRAY_WRITE_CMD
                         || next_shift == ARRAY_READ_CMD
                         || next_shift == FAST_ARRAY_READ_CMD) begin
              state <= SFC_ADDR;
            end else begin
              state <= SFC_IGNORE;                                   // other paths elsewhere
            end
          end
        end
        SFC_ADDR: begin
          if (byte_done) begin
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == ADDR_BYTES - 2'h1) begin
              state <= SFC_DATA;
            end
          end
        end
        SFC_DATA: begin
          if (byte_done && opcode == STATUS_WRITE_CMD) begin
            state <= SFC_IGNORE;                                     // one status byte only
          end
        end
        SFC_STREAM: state <= SFC_STREAM;
        SFC_IGNORE: state <= SFC_IGNORE;
        default:    state <= SFC_OPCODE;
      endcase
    end
  end

  // strobe of each accepted opcode for the neighbouring data path
  // downstream blocks act on opcode_o only while the strobe is high
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      opcode_o       <= 8'h00;
      opcode_valid_o <= 1'b0;
    end else begin
      opcode_valid_o <= (state == SFC_OPCODE) && byte_done && !cs_n_s
                        && is_defined(next_shift);
      if ((state == SFC_OPCODE) && byte_done) begin
        opcode_o <= next_shift;
      end
    end
  end

  // write enable latch; set and clear act only on complete opcodes
  // set and clear never meet: set needs select low, clear needs its rising edge
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      write_enable_flag <= 1'b0;
    end else if (cs_rise && clears_latch(opcode)) begin
      write_enable_flag <= 1'b0;
    end else if ((state == SFC_OPCODE) && byte_done && next_shift == LATCH_SET_CMD) begin
      write_enable_flag <= 1'b1;
    end
  end

  // a status byte counts only with the latch set and the pin guard open
  assign status_wr_ok = write_enable_flag && !(protect_pin_enable && !wp_n_s);

  // loaded marks that stored protect bits were taken after reset release
  // protect fields live in an outside nonvolatile store; we mirror and save them
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      loaded             <= 1'b0;
      protect_pin_enable <= 1'b0;
      block_protect_high <= 1'b0;
      block_protect_low  <= 1'b0;
      nv_save_o          <= 1'b0;
    end else begin
      nv_save_o <= 1'b0;
      if (!loaded) begin
        loaded             <= 1'b1;
        protect_pin_enable <= pin_en_stored_i;
        block_protect_high <= bp_stored_i[1];
        block_protect_low  <= bp_stored_i[0];
      end else if (state == SFC_DATA && opcode == STATUS_WRITE_CMD && byte_done
                   && status_wr_ok) begin
        protect_pin_enable <= next_shift[PIN_EN_BIT];
        block_protect_high <= next_shift[BP_HIGH_BIT];
        block_protect_low  <= next_shift[BP_LOW_BIT];
        nv_save_o          <= 1'b1;
      end
    end
  end

  // status image: fixed bits are constants so writes cannot reach them
  always_comb begin
    status_protect_reg                = 8'h00;
    status_protect_reg[PIN_EN_BIT]    = protect_pin_enable;
    status_protect_reg[FIXED_ONE_BIT] = 1'b1;
    status_protect_reg[BP_HIGH_BIT]   = block_protect_high;
    status_protect_reg[BP_LOW_BIT]    = block_protect_low;
    status_protect_reg[WEL_BIT]       = write_enable_flag;
    status_protect_reg[BUSY_BIT]      = waking_i;
  end

  // array address and per-byte write permit
  // once halted, a burst drops every later byte of the frame
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_o     <= 21'h000000;
      wdata_o    <= 8'h00;
      array_wr_o <= 1'b0;
      array_rd_o <= 1'b0;
      burst_halt <= 1'b0;
      status_o   <= STATUS_RESET;
    end else begin
      status_o   <= status_protect_reg;
      array_wr_o <= 1'b0;
      array_rd_o <= 1'b0;
      if (cs_fall) begin
        burst_halt <= 1'b0;
      end
      // the address stands beside its pulse and steps on in the next cycle
      if (array_wr_o || array_rd_o) begin
        addr_o <= addr_o + 21'h000001;                               // rolls over at top
      end
      if (state == SFC_ADDR && byte_done) begin
        addr_o <= {addr_o[12:0], next_shift};                        // upper bits dropped
      end
      if (state == SFC_DATA && byte_done && opcode == ARRAY_WRITE_CMD) begin
        wdata_o <= next_shift;
        if (!write_enable_flag || burst_halt
            || addr_protected({block_protect_high, block_protect_low}, addr_o)) begin
          burst_halt <= 1'b1;
        end else begin
          array_wr_o <= 1'b1;
        end
      end
      if (state == SFC_DATA && byte_done
          && (opcode == ARRAY_READ_CMD || opcode == FAST_ARRAY_READ_CMD)) begin
        array_rd_o <= 1'b1;                                          // read path elsewhere
      end
    end
  end

  // status byte loader and serial output on sck falls
  // the byte is re-armed every eighth fall, so a long read repeats it whole
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx        <= 8'h00;
      tx_on     <= 1'b0;
      so_o      <= 1'b0;
      so_oe_n_o <= 1'b1;
    end else if (cs_n_s || state != SFC_STREAM) begin
      tx_on     <= 1'b0;
      so_oe_n_o <= 1'b1;
      tx        <= status_protect_reg;
    end else if (sck_fall) begin
      so_oe_n_o <= 1'b0;
      so_o      <= tx_on ? tx[7] : status_protect_reg[7];
      tx        <= tx_on ? {tx[6:0], 1'b0} : {status_protect_reg[6:0], 1'b0};
      tx_on     <= 1'b1;
      if (bit_cnt == 3'h0 && tx_on) begin
        so_o <= status_protect_reg[7];                               // repeat the byte
        tx   <= {status_protect_reg[6:0], 1'b0};
      end
    end
  end
endmodule

// ### sfc_core_properties.sv
// Purpose: port-level checks on the command decoder and write protection block
// Assumes: one ref_clk_i domain, synchronous active low reset
// Notes:   idle windows allow for the synchroniser delay on the serial pins
`timescale 1ns/1ps
module sfc_core_properties
  import sfc_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        cs_n_i,
  input wire logic        sck_i,
  input wire logic        si_i,
  input wire logic        wp_n_i,
  input wire logic        waking_i,
  input wire logic [1:0]  bp_stored_i,
  input wire logic        pin_en_stored_i,
  input wire logic        so_o,
  input wire logic        so_oe_n_o,
  input wire logic [7:0]  status_o,
  input wire logic [20:0] addr_o,
  input wire logic [7:0]  wdata_o,
  input wire logic        array_wr_o,
  input wire logic        array_rd_o,
  input wire logic        nv_save_o,
  input wire logic [7:0]  opcode_o,
  input wire logic        opcode_valid_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // true when the address lies in the range locked by the protect code
  function automatic logic locked(logic [20:0] a, logic [1:0] bp);
    case (bp)
      2'h1:    return a >= 21'h180000;
      2'h2:    return a >= 21'h100000;
      2'h3:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // fixed fields and status flags
  a_fixed_bits: assert property (status_o[6:4] == 3'b100)
    else $error("fixed status bits wrong");
  a_busy_mirror: assert property (
    $past(rst_n_i, 3) && waking_i == $past(waking_i) && waking_i == $past(waking_i, 2)
    && waking_i == $past(waking_i, 3) |-> status_o[0] == waking_i)
    else $error("busy bit does not follow wake state");
  // the output stays off while deselected, after sync delay
  a_idle_off: assert property (cs_n_i [*5] |-> so_oe_n_o)
    else $error("serial output driven while deselected");
  // the latch only sets inside a frame, never from idle
  a_latch_hold: assert property (cs_n_i [*6] |-> !$rose(status_o[1]))
    else $error("latch set without a command");
  // status writes need the latch and an open pin guard
  a_save_allowed: assert property (
    nv_save_o |-> status_o[1] && ($past(wp_n_i, 3) || !$past(status_o[7], 2)))
    else $error("status saved while guarded");
  a_save_keeps: assert property (nv_save_o |-> ##2 status_o[1])
    else $error("status write altered the latch bit");
  // array byte writes need the latch and an unlocked address
  a_wr_latch: assert property (array_wr_o |-> status_o[1])
    else $error("array write without latch");
  a_wr_range: assert property (array_wr_o |-> !locked(addr_o, status_o[3:2]))
    else $error("array write into locked range");
  a_valid_pulse: assert property (
    opcode_valid_o |=> !opcode_valid_o && opcode_o inside {8'h06, 8'h04, 8'h05, 8'h01,
    8'h02, 8'h03, 8'h0B, 8'h42, 8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3, 8'hBA, 8'hB9})
    else $error("bad opcode valid pulse");
endmodule

// ### sfc_spi_master.sv
// Purpose: spi bus master model driving the serial pins in mode 0
// Assumes: 160 ns serial clock that stands low outside frames
// Notes:   an undriven output line reads back as the inverse of the last bit
`timescale 1ns/1ps
module sfc_spi_master (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_n_i
);
  localparam time HALF = 80ns;
  // idle bus: deselected, clock low
  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end
  // every command opens a frame of its own
  task automatic select();
    #HALF cs_n_o = 1'b0;
    #HALF;
  endtask
  // released data line flips so a stale level never passes for data
  task automatic deselect();
    #HALF cs_n_o = 1'b1;
    si_o = ~si_o;
    #(4 * HALF);
  endtask
  // msb first; data set while the clock is low, read just before the fall
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_o = tx[i];
      #HALF sck_o = 1'b1;
      #HALF rx = {rx[6:0], so_oe_n_i ? ~rx[0] : so_i};
      sck_o = 1'b0;
    end
  endtask
endmodule

// ### tb_top.sv
// Purpose: self-checking bench for the command decoder and protection block
// Assumes: 50 MHz system clock, mode 0 master at 160 ns
// Notes:   status is judged through a real status read frame, apart from the reset value read from status_o
`timescale 1ns/1ps
module tb_top;
  import sfc_pkg::*;
  typedef struct packed {
    logic       latch_set_cmd;
    logic [7:0] wdat;
    logic       wp_n;
    logic [7:0] exp;
  } sfc_row_t;
  localparam int LIMIT = 80000;
  // status write cases: latch, byte written, pin level, status expected after
  localparam sfc_row_t ROWS [6] = '{'{1'b0, 8'h8C, 1'b1, 8'h40}, '{1'b1, 8'hBF, 1'b1, 8'hCC},
    '{1'b1, 8'h00, 1'b0, 8'hCC}, '{1'b1, 8'h04, 1'b1, 8'h44}, '{1'b1, 8'h88, 1'b0, 8'hC8},
    '{1'b1, 8'h00, 1'b1, 8'h40}};
  localparam logic [7:0] OPS [15] = '{LATCH_SET_CMD, LATCH_CLEAR_CMD, STATUS_READ_CMD,
    STATUS_WRITE_CMD, ARRAY_WRITE_CMD, ARRAY_READ_CMD, FAST_ARRAY_READ_CMD,
    SPECIAL_SECTOR_WRITE_CMD, SPECIAL_SECTOR_READ_CMD, IDENTIFIER_READ_CMD,
    UNIQUE_IDENTIFIER_READ_CMD, SERIAL_NUMBER_WRITE_CMD, SERIAL_NUMBER_READ_CMD,
    DEEP_SLEEP_CMD, HIBERNATE_CMD};
  localparam logic [7:0] CLEARS [4] = '{LATCH_CLEAR_CMD, ARRAY_WRITE_CMD,
    SPECIAL_SECTOR_WRITE_CMD, SERIAL_NUMBER_WRITE_CMD};
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        wp_n    = 1'b1;
  logic        waking  = 1'b0;
  logic [1:0]  bp_st   = 2'h0;
  logic        pen_st  = 1'b0;
  logic        cs_n, sck, si, so, so_oe_n, awr, ard, nv_save, op_valid;
  logic [7:0]  status, wdata, opcode, last_dat;
  logic [20:0] addr, last_wr;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_wr, n_rd, n_sv, n_valid, n_drive, cyc;

  // clock generator
  always #10 clk = ~clk;

  sfc_core sfc_core_i (.ref_clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck),
    .si_i(si), .wp_n_i(wp_n), .waking_i(waking), .bp_stored_i(bp_st),
    .pin_en_stored_i(pen_st), .so_o(so), .so_oe_n_o(so_oe_n), .status_o(status),
    .addr_o(addr), .wdata_o(wdata), .array_wr_o(awr), .array_rd_o(ard),
    .nv_save_o(nv_save), .opcode_o(opcode), .opcode_valid_o(op_valid));
  sfc_spi_master sfc_spi_master_i (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so),
    .so_oe_n_i(so_oe_n));

  // pulse monitor and hang guard; the limit is well above the planned frames
  always @(posedge clk) begin
    cyc++;
    if (awr === 1'b1) begin
      n_wr++;
      last_wr = addr;
      last_dat = wdata;
    end
    if (ard === 1'b1) n_rd++;
    if (nv_save === 1'b1) n_sv++;
    if (op_valid === 1'b1) n_valid++;
    if (so_oe_n === 1'b0) n_drive++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one byte out, reply dropped
  task automatic tx(input logic [7:0] b);
    logic [7:0] r;
    sfc_spi_master_i.xfer(b, 8, r);
  endtask

  // single-opcode frame
  task automatic cmd(input logic [7:0] op);
    sfc_spi_master_i.select();
    tx(op);
    sfc_spi_master_i.deselect();
  endtask

  task automatic wr_status(input logic [7:0] b);
    sfc_spi_master_i.select();
    tx(STATUS_WRITE_CMD);
    tx(b);
    sfc_spi_master_i.deselect();
  endtask

  // reads the status byte twice over the serial pins, as a long read repeats it
  task automatic chk_st(input logic [7:0] exp);
    logic [7:0] r, r2;
    sfc_spi_master_i.select();
    tx(STATUS_READ_CMD);
    sfc_spi_master_i.xfer(8'h00, 8, r);
    sfc_spi_master_i.xfer(8'h00, 8, r2);
    sfc_spi_master_i.deselect();
    chk("status", 21'(exp), 21'(r));
    chk("status_repeat", 21'(exp), 21'(r2));
  endtask

  // array burst: opcode, three address bytes, n data bytes
  task automatic arr_wr(input logic [7:0] op, input logic [20:0] a, input int n);
    n_wr = 0;
    n_rd = 0;
    sfc_spi_master_i.select();
    tx(op);
    tx({3'h0, a[20:16]});
    tx(a[15:8]);
    tx(a[7:0]);
    repeat (n) tx(8'hA5);
    sfc_spi_master_i.deselect();
  endtask

  // main sequence: table of status writes, then hand-written cases
  initial begin
    logic [7:0] prev;
    logic [7:0] s;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    prev = STATUS_RESET;
    chk("status_o", 21'(STATUS_RESET), 21'(status));
    foreach (ROWS[i]) begin
      @(negedge clk) wp_n = ROWS[i].wp_n;
      if (ROWS[i].latch_set_cmd) begin
        cmd(LATCH_SET_CMD);
        chk_st(prev | 8'h02);
      end
      n_sv = 0;
      wr_status(ROWS[i].wdat);
      chk_st(ROWS[i].exp);
      chk("nv_save_o", 21'(ROWS[i].exp != prev), 21'(n_sv));
      prev = ROWS[i].exp;
    end
    // second reset reloads the stored protect fields
    @(negedge clk);
    rst_n = 1'b0;
    bp_st = 2'h3;
    pen_st = 1'b1;
    repeat (3) @(negedge clk);
    chk("status_o", 21'(STATUS_RESET), 21'(status));
    chk("so_oe_n_o", 21'h1, 21'(so_oe_n));
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk_st(8'hCC);
    // array protection: whole array, upper quarter, missing latch
    @(negedge clk) wp_n = 1'b0;
    cmd(LATCH_SET_CMD);
    arr_wr(ARRAY_WRITE_CMD, 21'h000000, 2);
    chk("writes", 21'h0, 21'(n_wr));
    @(negedge clk) wp_n = 1'b1;
    cmd(LATCH_SET_CMD);
    wr_status(8'h84);
    @(negedge clk) wp_n = 1'b0;
    cmd(LATCH_SET_CMD);
    arr_wr(ARRAY_WRITE_CMD, 21'h17FFFF, 3);
    chk("writes", 21'h1, 21'(n_wr));
    chk("addr_o", 21'h17FFFF, last_wr);
    chk("wdata_o", 21'hA5, 21'(last_dat));
    arr_wr(ARRAY_WRITE_CMD, 21'h000000, 1);
    chk("writes", 21'h0, 21'(n_wr));
    // commands that clear the latch at frame end, and one that must not
    foreach (CLEARS[i]) begin
      cmd(LATCH_SET_CMD);
      cmd(CLEARS[i]);
      chk_st(8'hC4);
    end
    cmd(LATCH_SET_CMD);
    cmd(ARRAY_READ_CMD);
    chk_st(8'hC6);
    arr_wr(ARRAY_READ_CMD, 21'h1FFFFF, 2);
    chk("reads", 21'h2, 21'(n_rd));
    chk("addr_o", 21'h000001, addr);
    // every defined opcode decodes once
    foreach (OPS[i]) begin
      n_valid = 0;
      cmd(OPS[i]);
      chk("opcode_o", 21'(OPS[i]), 21'(opcode));
      chk("valid", 21'h1, 21'(n_valid));
    end
    // undefined opcode: frame ignored, output stays off
    n_valid = 0;
    n_drive = 0;
    sfc_spi_master_i.select();
    tx(8'hFF);
    tx(STATUS_READ_CMD);
    sfc_spi_master_i.deselect();
    chk("valid", 21'h0, 21'(n_valid));
    chk("drive", 21'h0, 21'(n_drive));
    // short opcode, then a second opcode inside one frame
    sfc_spi_master_i.select();
    sfc_spi_master_i.xfer(LATCH_SET_CMD, 7, s);
    sfc_spi_master_i.deselect();
    chk_st(8'hC4);
    sfc_spi_master_i.select();
    tx(STATUS_READ_CMD);
    tx(LATCH_SET_CMD);
    sfc_spi_master_i.deselect();
    chk_st(8'hC4);
    @(negedge clk) waking = 1'b1;
    chk_st(8'hC5);
    @(negedge clk) waking = 1'b0;
    complete_run();
  end
endmodule

bind sfc_core sfc_core_properties sfc_core_properties_i (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i),
  .waking_i(waking_i), .bp_stored_i(bp_stored_i), .pin_en_stored_i(pin_en_stored_i),
  .so_o(so_o), .so_oe_n_o(so_oe_n_o), .status_o(status_o), .addr_o(addr_o),
  .wdata_o(wdata_o), .array_wr_o(array_wr_o), .array_rd_o(array_rd_o),
  .nv_save_o(nv_save_o), .opcode_o(opcode_o), .opcode_valid_o(opcode_valid_o));
